// ===== sdc_consts.svh
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH
// register addresses on the special function register bus
`define SDC_ADDR_MUX 8'hdb
`define SDC_ADDR_STAT 8'hda
`define SDC_ADDR_ACTL 8'hdc
`define SDC_ADDR_CCTL 8'hdd
`define SDC_ADDR_DECLO 8'hde
`define SDC_ADDR_DECHI 8'hdf
`define SDC_ADDR_OFFSET_DAC_REG 8'he6
`define SDC_ADDR_ACLK 8'hf6
// reset values
`define SDC_RST_MUX 8'h01
`define SDC_RST_ACTL 8'h30
`define SDC_RST_CCTL 8'h00
`define SDC_RST_OFFSET_DAC_REG 8'h00
`define SDC_RST_ACLK 8'h00
`define SDC_RST_DECLO 8'h00
`define SDC_RST_DECHI 8'h01
// input selector fields; all ones selects the temperature diodes
`define SDC_MUX_TEMP 8'hff
`define SDC_MUX_SWAP 7
`define SDC_MUX_POS_HI 6
`define SDC_MUX_POS_LO 4
`define SDC_MUX_NEG_HI 2
`define SDC_MUX_NEG_LO 0
// analog control fields
`define SDC_ACTL_BOD 6
`define SDC_ACTL_REFHI 5
`define SDC_ACTL_REFEN 4
`define SDC_ACTL_BUF 3
`define SDC_ACTL_GAIN_HI 2
`define SDC_ACTL_GAIN_LO 0
// calibration control fields
`define SDC_CCTL_FILT_HI 5
`define SDC_CCTL_FILT_LO 4
`define SDC_CCTL_CAL_HI 2
`define SDC_CCTL_CAL_LO 0
// status fields
`define SDC_STAT_FLAG 0
`define SDC_STAT_BUSY 1
// offset dac fields
`define SDC_OFFSET_DAC_REG_SIGN 7
// calibration codes
`define SDC_CAL_NONE 3'h0
`define SDC_CAL_SELF_BOTH 3'h1
`define SDC_CAL_SYS_OFS 3'h4
`define SDC_CAL_SYS_GAIN 3'h5
// periods per calibration
`define SDC_CAL_ONE 4'h7
`define SDC_CAL_TWO 4'he
// modulator divide factor minus one
`define SDC_MOD_LAST 6'h3f
`endif

// ===== sdc_pkg.sv
package sdc_pkg;
  typedef enum logic [1:0] {
    SDC_FILT_AUTO = 2'h0,
    SDC_FILT_FAST = 2'h1,
    SDC_FILT_SINC2 = 2'h2,
    SDC_FILT_SINC3 = 2'h3
  } sdc_filt_t;
  typedef enum logic [2:0] {
    SDC_DS_IDLE = 3'b001,
    SDC_DS_CONV = 3'b010,
    SDC_DS_CAL = 3'b100
  } sdc_dstate_t;
  typedef enum logic [3:0] {
    SDC_HS_IDLE = 4'b0001,
    SDC_HS_OFFSET_DAC_REG = 4'b0010,
    SDC_HS_CAL = 4'b0100,
    SDC_HS_RD = 4'b1000
  } sdc_hstate_t;
endpackage : sdc_pkg

// ===== sdc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdc_if #(parameter int unsigned SAMPLE_W = 24);
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_we;
  logic sfr_re;
  logic [7:0] sfr_rdata;
  logic sfr_rvalid;
  logic [SAMPLE_W-1:0] res_data;
  logic res_valid;
  logic res_ready;
  modport dev (input sfr_addr, sfr_wdata, sfr_we, sfr_re, res_ready,
    output sfr_rdata, sfr_rvalid, res_data, res_valid);
  modport host (output sfr_addr, sfr_wdata, sfr_we, sfr_re, res_ready,
    input sfr_rdata, sfr_rvalid, res_data, res_valid);
endinterface : sdc_if
`default_nettype wire

// ===== sdc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_fifo #(
  parameter int unsigned W = 24,
  parameter int unsigned D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // count next value; flags are registered from it so they stay honest
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) cnt_d = cnt_q + 1'b1;
    if (pop && !push) cnt_d = cnt_q - 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      wr_q <= '0;
      rd_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != (AW+1)'(D));
      out_valid <= (cnt_d != '0);
      if (push) wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
    end
  end
  // storage carries no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (ce && push) mem_q[wr_q] <= in_data;
  end
  assign out_data = mem_q[rd_q];
endmodule : sdc_fifo
`default_nettype wire

// ===== sdc_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_device #(
  parameter int unsigned SAMPLE_W = 24,
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  sdc_if.dev BUS,
  input wire logic [SAMPLE_W-1:0] SAMPLE,
  output logic [2:0] POS_SEL,
  output logic [2:0] NEG_SEL,
  output logic CHAN_EN,
  output logic TEMP_DIODE_EN,
  output logic BURNOUT_EN,
  output logic BUFFER_EN,
  output logic [2:0] GAIN_CODE,
  output logic OFFSET_DAC_REG_SIGN,
  output logic [6:0] OFFSET_DAC_REG_MAG,
  output logic REF_INT_EN,
  output logic REF_HIGH,
  output logic MOD_TICK,
  output logic [1:0] FILTER_SEL,
  output logic CAL_ACTIVE,
  output logic [2:0] CAL_CODE
);
  logic [7:0] mux_q, actl_q, cctl_q, offset_dac_reg_q, aclk_q, declo_q, dechi_q;
  logic flag_q;
  logic [7:0] aclk_cnt_q;
  logic [5:0] mod_cnt_q;
  logic [15:0] dec_cnt_q, ratio_m1;
  logic [3:0] cal_cnt_q, cal_need;
  logic [1:0] settle_q;
  sdc_pkg::sdc_dstate_t st_q;
  sdc_pkg::sdc_filt_t filt_mode, filt_eff;
  logic aclk_tick, mod_tick, dec_last, conv_tick, cal_done, cal_start;
  logic discard, push, fifo_ready, wr_sel_chg;
  logic [2:0] cal_sel;
  assign cal_sel = cctl_q[`SDC_CCTL_CAL_HI:`SDC_CCTL_CAL_LO];
  assign filt_mode = sdc_pkg::sdc_filt_t'(cctl_q[`SDC_CCTL_FILT_HI:`SDC_CCTL_FILT_LO]);

  // clock chain: divider, fixed /64, then decimation
  assign aclk_tick = (aclk_cnt_q >= aclk_q); // a shrunk divisor must not wrap
  assign mod_tick = aclk_tick && (mod_cnt_q == `SDC_MOD_LAST);
  assign ratio_m1 = ({dechi_q, declo_q} == 16'h0000) ? 16'h0000
    : {dechi_q, declo_q} - 16'h0001;
  assign dec_last = (dec_cnt_q >= ratio_m1);
  // a full fifo holds the conversion back rather than losing a result
  assign conv_tick = mod_tick && dec_last && fifo_ready;

  // calibration sequencing
  assign cal_start = BUS.sfr_we && (BUS.sfr_addr == `SDC_ADDR_CCTL)
    && (BUS.sfr_wdata[`SDC_CCTL_CAL_HI:`SDC_CCTL_CAL_LO] != `SDC_CAL_NONE);
  assign cal_need = (cal_sel == `SDC_CAL_SELF_BOTH) ? `SDC_CAL_TWO : `SDC_CAL_ONE;
  assign cal_done = (st_q == sdc_pkg::SDC_DS_CAL) && conv_tick
    && (cal_cnt_q == cal_need - 4'h1);

  // effective filter; auto walks fast, fast, sinc2, sinc3
  always_comb begin
    filt_eff = filt_mode;
    if (filt_mode == sdc_pkg::SDC_FILT_AUTO) begin
      if (settle_q < 2'h2) filt_eff = sdc_pkg::SDC_FILT_FAST;
      else if (settle_q == 2'h2) filt_eff = sdc_pkg::SDC_FILT_SINC2;
      else filt_eff = sdc_pkg::SDC_FILT_SINC3;
    end
  end
  assign discard = (filt_mode == sdc_pkg::SDC_FILT_AUTO) && (settle_q == 2'h0);
  assign push = conv_tick && (st_q == sdc_pkg::SDC_DS_CONV) && !discard;
  assign wr_sel_chg = BUS.sfr_we && ((BUS.sfr_addr == `SDC_ADDR_MUX)
    || ((BUS.sfr_addr == `SDC_ADDR_ACTL) && (BUS.sfr_wdata[`SDC_ACTL_GAIN_HI:
    `SDC_ACTL_GAIN_LO] != actl_q[`SDC_ACTL_GAIN_HI:`SDC_ACTL_GAIN_LO])));

  // software-written registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mux_q <= `SDC_RST_MUX;
      actl_q <= `SDC_RST_ACTL;
      offset_dac_reg_q <= `SDC_RST_OFFSET_DAC_REG;
      aclk_q <= `SDC_RST_ACLK;
      declo_q <= `SDC_RST_DECLO;
      dechi_q <= `SDC_RST_DECHI;
    end else if (CE && BUS.sfr_we) begin
      case (BUS.sfr_addr)
        `SDC_ADDR_MUX: mux_q <= BUS.sfr_wdata;
        `SDC_ADDR_ACTL: actl_q <= BUS.sfr_wdata;
        `SDC_ADDR_OFFSET_DAC_REG: offset_dac_reg_q <= BUS.sfr_wdata;
        `SDC_ADDR_ACLK: aclk_q <= BUS.sfr_wdata;
        `SDC_ADDR_DECLO: declo_q <= BUS.sfr_wdata;
        `SDC_ADDR_DECHI: dechi_q <= BUS.sfr_wdata;
        default: ;
      endcase
    end
  end

  // calibration control: software write wins, else hardware clears at end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) cctl_q <= `SDC_RST_CCTL;
    else if (CE) begin
      if (BUS.sfr_we && (BUS.sfr_addr == `SDC_ADDR_CCTL)) cctl_q <= BUS.sfr_wdata;
      else if (cal_done) cctl_q[`SDC_CCTL_CAL_HI:`SDC_CCTL_CAL_LO] <= `SDC_CAL_NONE;
    end
  end

  // converter flag: a new event beats a same-cycle clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) flag_q <= 1'b0;
    else if (CE) begin
      if (push || cal_done) flag_q <= 1'b1;
      else if (BUS.sfr_we && (BUS.sfr_addr == `SDC_ADDR_STAT)
        && BUS.sfr_wdata[`SDC_STAT_FLAG]) flag_q <= 1'b0;
    end
  end

  // clock chain counters
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aclk_cnt_q <= 8'h00;
      mod_cnt_q <= 6'h00;
      dec_cnt_q <= 16'h0000;
    end else if (CE) begin
      aclk_cnt_q <= aclk_tick ? 8'h00 : aclk_cnt_q + 8'h01;
      if (aclk_tick) mod_cnt_q <= mod_cnt_q + 6'h01;
      if (conv_tick) dec_cnt_q <= 16'h0000;
      else if (mod_tick && !dec_last) dec_cnt_q <= dec_cnt_q + 16'h0001;
    end
  end

  // state: idle for one enabled cycle after reset, then converting, or calibrating
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= sdc_pkg::SDC_DS_IDLE;
      cal_cnt_q <= 4'h0;
    end else if (CE) begin
      case (st_q)
        sdc_pkg::SDC_DS_IDLE, sdc_pkg::SDC_DS_CONV: begin
          st_q <= sdc_pkg::SDC_DS_CONV;
          if (cal_start) begin
            st_q <= sdc_pkg::SDC_DS_CAL;
            cal_cnt_q <= 4'h0;
          end
        end
        sdc_pkg::SDC_DS_CAL: begin
          if (cal_start) cal_cnt_q <= 4'h0;
          else if (cal_done) st_q <= sdc_pkg::SDC_DS_CONV;
          else if (conv_tick) cal_cnt_q <= cal_cnt_q + 4'h1;
        end
        default: st_q <= sdc_pkg::SDC_DS_IDLE;
      endcase
    end
  end

  // settling count restarts on channel or gain change
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) settle_q <= 2'h0;
    else if (CE) begin
      if (wr_sel_chg) settle_q <= 2'h0;
      else if (conv_tick && st_q == sdc_pkg::SDC_DS_CONV && settle_q != 2'h3)
        settle_q <= settle_q + 2'h1;
    end
  end

  // read port: one cycle latency, unmapped read zero, data stands until next read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS.sfr_rdata <= 8'h00;
      BUS.sfr_rvalid <= 1'b0;
    end else if (CE) begin
      BUS.sfr_rvalid <= BUS.sfr_re;
      if (BUS.sfr_re) begin
        case (BUS.sfr_addr)
          `SDC_ADDR_MUX: BUS.sfr_rdata <= mux_q;
          `SDC_ADDR_STAT: BUS.sfr_rdata <= {6'h00, st_q == sdc_pkg::SDC_DS_CAL, flag_q};
          `SDC_ADDR_ACTL: BUS.sfr_rdata <= actl_q;
          `SDC_ADDR_CCTL: BUS.sfr_rdata <= cctl_q;
          `SDC_ADDR_OFFSET_DAC_REG: BUS.sfr_rdata <= offset_dac_reg_q;
          `SDC_ADDR_ACLK: BUS.sfr_rdata <= aclk_q;
          `SDC_ADDR_DECLO: BUS.sfr_rdata <= declo_q;
          `SDC_ADDR_DECHI: BUS.sfr_rdata <= dechi_q;
          default: BUS.sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

  // analog front-end controls, registered so every pin is a flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      POS_SEL <= 3'h0;
      NEG_SEL <= 3'h0;
      CHAN_EN <= 1'b0;
      TEMP_DIODE_EN <= 1'b0;
      BURNOUT_EN <= 1'b0;
      BUFFER_EN <= 1'b0;
      GAIN_CODE <= 3'h0;
      OFFSET_DAC_REG_SIGN <= 1'b0;
      OFFSET_DAC_REG_MAG <= 7'h00;
      REF_INT_EN <= 1'b0;
      REF_HIGH <= 1'b0;
      MOD_TICK <= 1'b0;
      FILTER_SEL <= 2'h0;
      CAL_ACTIVE <= 1'b0;
      CAL_CODE <= 3'h0;
    end else if (CE) begin
      if (mux_q == `SDC_MUX_TEMP) begin
        // diodes only; every channel switch left open
        TEMP_DIODE_EN <= 1'b1;
        CHAN_EN <= 1'b0;
        POS_SEL <= 3'h0;
        NEG_SEL <= 3'h0;
      end else begin
        TEMP_DIODE_EN <= 1'b0;
        CHAN_EN <= 1'b1;
        POS_SEL <= mux_q[`SDC_MUX_SWAP] ? mux_q[`SDC_MUX_NEG_HI:`SDC_MUX_NEG_LO]
          : mux_q[`SDC_MUX_POS_HI:`SDC_MUX_POS_LO];
        NEG_SEL <= mux_q[`SDC_MUX_SWAP] ? mux_q[`SDC_MUX_POS_HI:`SDC_MUX_POS_LO]
          : mux_q[`SDC_MUX_NEG_HI:`SDC_MUX_NEG_LO];
      end
      BURNOUT_EN <= actl_q[`SDC_ACTL_BOD];
      BUFFER_EN <= actl_q[`SDC_ACTL_BUF];
      GAIN_CODE <= actl_q[`SDC_ACTL_GAIN_HI:`SDC_ACTL_GAIN_LO];
      OFFSET_DAC_REG_SIGN <= offset_dac_reg_q[`SDC_OFFSET_DAC_REG_SIGN];
      OFFSET_DAC_REG_MAG <= offset_dac_reg_q[`SDC_OFFSET_DAC_REG_SIGN-1:0];
      REF_INT_EN <= actl_q[`SDC_ACTL_REFEN];
      REF_HIGH <= actl_q[`SDC_ACTL_REFHI];
      MOD_TICK <= mod_tick;
      FILTER_SEL <= filt_eff;
      CAL_ACTIVE <= (st_q == sdc_pkg::SDC_DS_CAL);
      CAL_CODE <= cal_sel;
    end
  end

  sdc_fifo #(.W(SAMPLE_W), .D(FIFO_DEPTH)) sdc_fifo_inst (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .in_data(SAMPLE),
    .in_valid(push),
    .in_ready(fifo_ready),
    .out_data(BUS.res_data),
    .out_valid(BUS.res_valid),
    .out_ready(BUS.res_ready)
  );
endmodule : sdc_device
`default_nettype wire

// ===== sdc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_host #(
  parameter int unsigned SAMPLE_W = 24
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  sdc_if.host BUS,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic CMD_CAL,
  input wire logic [7:0] CMD_ADDR,
  input wire logic [7:0] CMD_WDATA,
  input wire logic REF_EXT_USED,
  output logic CMD_READY,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic ZERO_INPUT_REQ,
  output logic FULLSCALE_REQ,
  output logic RECAL_NEEDED,
  output logic [SAMPLE_W-1:0] RES_DATA,
  output logic RES_VALID,
  input wire logic RES_READY
);
  sdc_pkg::sdc_hstate_t st_q;
  logic [7:0] cal_code_q;
  logic [7:0] wdata;
  logic chg;
  logic [2:0] cmd_cal_sel;
  assign cmd_cal_sel = CMD_WDATA[`SDC_CCTL_CAL_HI:`SDC_CCTL_CAL_LO];
  // unused internal reference is forced off on the way out
  assign wdata = (CMD_ADDR == `SDC_ADDR_ACTL && REF_EXT_USED)
    ? (CMD_WDATA & ~(8'h01 << `SDC_ACTL_REFEN)) : CMD_WDATA;
  assign chg = CMD_WRITE && (CMD_ADDR == `SDC_ADDR_ACTL || CMD_ADDR == `SDC_ADDR_DECLO
    || CMD_ADDR == `SDC_ADDR_DECHI);

  // bus sequencer; a calibration first zeroes the offset dac
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= sdc_pkg::SDC_HS_IDLE;
      BUS.sfr_addr <= 8'h00;
      BUS.sfr_wdata <= 8'h00;
      BUS.sfr_we <= 1'b0;
      BUS.sfr_re <= 1'b0;
      CMD_READY <= 1'b0;
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
      cal_code_q <= 8'h00;
    end else if (CE) begin
      BUS.sfr_we <= 1'b0;
      BUS.sfr_re <= 1'b0;
      RD_VALID <= 1'b0;
      case (st_q)
        sdc_pkg::SDC_HS_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            if (CMD_CAL) begin
              cal_code_q <= CMD_WDATA;
              BUS.sfr_addr <= `SDC_ADDR_OFFSET_DAC_REG;
              BUS.sfr_wdata <= `SDC_RST_OFFSET_DAC_REG;
              BUS.sfr_we <= 1'b1;
              st_q <= sdc_pkg::SDC_HS_OFFSET_DAC_REG;
            end else if (CMD_WRITE) begin
              BUS.sfr_addr <= CMD_ADDR;
              BUS.sfr_wdata <= wdata;
              BUS.sfr_we <= 1'b1;
            end else begin
              BUS.sfr_addr <= CMD_ADDR;
              BUS.sfr_re <= 1'b1;
              st_q <= sdc_pkg::SDC_HS_RD;
            end
          end
        end
        sdc_pkg::SDC_HS_OFFSET_DAC_REG: begin
          BUS.sfr_addr <= `SDC_ADDR_CCTL;
          BUS.sfr_wdata <= cal_code_q;
          BUS.sfr_we <= 1'b1;
          st_q <= sdc_pkg::SDC_HS_CAL;
        end
        sdc_pkg::SDC_HS_CAL: st_q <= sdc_pkg::SDC_HS_IDLE;
        sdc_pkg::SDC_HS_RD: begin
          if (BUS.sfr_rvalid) begin
            RD_DATA <= BUS.sfr_rdata;
            RD_VALID <= 1'b1;
            st_q <= sdc_pkg::SDC_HS_IDLE;
          end
        end
        default: st_q <= sdc_pkg::SDC_HS_IDLE;
      endcase
    end
  end

  // analog stimulus requests and recalibration reminder
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ZERO_INPUT_REQ <= 1'b0;
      FULLSCALE_REQ <= 1'b0;
      RECAL_NEEDED <= 1'b1;
    end else if (CE) begin
      if (CMD_VALID && CMD_READY && CMD_CAL) begin
        ZERO_INPUT_REQ <= (cmd_cal_sel == `SDC_CAL_SYS_OFS);
        FULLSCALE_REQ <= (cmd_cal_sel == `SDC_CAL_SYS_GAIN);
        RECAL_NEEDED <= 1'b0;
      end else if (CMD_VALID && CMD_READY && chg) begin
        RECAL_NEEDED <= 1'b1;
      end
    end
  end

  // one-word result holding register toward the user
  assign BUS.res_ready = !RES_VALID || RES_READY;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RES_DATA <= '0;
      RES_VALID <= 1'b0;
    end else if (CE) begin
      if (BUS.res_valid && BUS.res_ready) begin
        RES_DATA <= BUS.res_data;
        RES_VALID <= 1'b1;
      end else if (RES_READY) RES_VALID <= 1'b0;
    end
  end
endmodule : sdc_host
`default_nettype wire

// ===== sdc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_checker #(
  parameter int unsigned SAMPLE_W = 24
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic [SAMPLE_W-1:0] res_data,
  input wire logic res_valid,
  input wire logic res_ready
);
  logic [7:0] mux_q, actl_q, offset_dac_reg_q, aclk_q, dlo_q, dhi_q, ra_q;
  logic [1:0] filt_q;
  logic mapped;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // mirror of the last value written; reads must give it back, bar selector bit 3, analog control bit 7 and cctl outside its filter field
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mux_q <= `SDC_RST_MUX;
      actl_q <= `SDC_RST_ACTL;
      offset_dac_reg_q <= `SDC_RST_OFFSET_DAC_REG;
      aclk_q <= `SDC_RST_ACLK;
      dlo_q <= `SDC_RST_DECLO;
      dhi_q <= `SDC_RST_DECHI;
      filt_q <= 2'h0;
    end else if (sfr_we) begin
      case (sfr_addr)
        `SDC_ADDR_MUX: mux_q <= sfr_wdata;
        `SDC_ADDR_ACTL: actl_q <= sfr_wdata;
        `SDC_ADDR_OFFSET_DAC_REG: offset_dac_reg_q <= sfr_wdata;
        `SDC_ADDR_ACLK: aclk_q <= sfr_wdata;
        `SDC_ADDR_DECLO: dlo_q <= sfr_wdata;
        `SDC_ADDR_DECHI: dhi_q <= sfr_wdata;
        `SDC_ADDR_CCTL: filt_q <= sfr_wdata[5:4];
        default: ;
      endcase
    end
  end
  // address of the read in flight
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ra_q <= 8'h00;
    end else if (sfr_re) begin
      ra_q <= sfr_addr;
    end
  end
  // status is not mirrored: its flag moves by itself
  assign mapped = ra_q inside {`SDC_ADDR_MUX, `SDC_ADDR_STAT, `SDC_ADDR_ACTL, `SDC_ADDR_CCTL,
    `SDC_ADDR_DECLO, `SDC_ADDR_DECHI, `SDC_ADDR_OFFSET_DAC_REG, `SDC_ADDR_ACLK};
  property p_mux_rd;
    sfr_rvalid && ra_q == `SDC_ADDR_MUX |-> (sfr_rdata & 8'hf7) == (mux_q & 8'hf7);
  endproperty
  a_mux_rd: assert property (p_mux_rd) else $error("selector read differs");
  property p_actl_rd;
    sfr_rvalid && ra_q == `SDC_ADDR_ACTL |-> sfr_rdata[6:0] == actl_q[6:0];
  endproperty
  a_actl_rd: assert property (p_actl_rd) else $error("analog control read differs");
  property p_offset_dac_reg_rd;
    sfr_rvalid && ra_q == `SDC_ADDR_OFFSET_DAC_REG |-> sfr_rdata == offset_dac_reg_q;
  endproperty
  a_offset_dac_reg_rd: assert property (p_offset_dac_reg_rd) else $error("offset read differs");
  property p_aclk_rd;
    sfr_rvalid && ra_q == `SDC_ADDR_ACLK |-> sfr_rdata == aclk_q;
  endproperty
  a_aclk_rd: assert property (p_aclk_rd) else $error("divisor read differs");
  property p_dlo_rd;
    sfr_rvalid && ra_q == `SDC_ADDR_DECLO |-> sfr_rdata == dlo_q;
  endproperty
  a_dlo_rd: assert property (p_dlo_rd) else $error("ratio low read differs");
  property p_dhi_rd;
    sfr_rvalid && ra_q == `SDC_ADDR_DECHI |-> sfr_rdata == dhi_q;
  endproperty
  a_dhi_rd: assert property (p_dhi_rd) else $error("ratio high read differs");
  property p_filt_rd;
    sfr_rvalid && ra_q == `SDC_ADDR_CCTL |-> sfr_rdata[5:4] == filt_q;
  endproperty
  a_filt_rd: assert property (p_filt_rd) else $error("filter field differs");
  property p_unmapped_rd;
    sfr_rvalid && !mapped |-> sfr_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_rd_answer;
    sfr_re |=> sfr_rvalid ##1 !sfr_rvalid || $past(sfr_re);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late or long");
  property p_res_hold;
    res_valid && !res_ready |=> res_valid && $stable(res_data);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result dropped while stalled");
endmodule : sdc_checker
`default_nettype wire

// ===== sigma_delta_adc_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module sigma_delta_adc_control_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic c_val = 1'b0;
  logic c_wr = 1'b0;
  logic c_cal = 1'b0;
  logic [7:0] c_addr = 8'h00;
  logic [7:0] c_data = 8'h00;
  logic ref_ext = 1'b0;
  logic res_rdy = 1'b1;
  logic ce = 1'b1;
  logic [23:0] sample = 24'h00_0000;
  logic [2:0] pos, neg, gain, ccode;
  logic chan, temp, bo, bf, osg, rint, rhi, tick, cact, crdy, rdv, zreq, freq, recal, rv;
  logic [6:0] omag;
  logic [1:0] filt;
  logic [7:0] rdd;
  logic [23:0] rd24;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int nres = 0;
  int nrdv = 0;
  sdc_if #(.SAMPLE_W(24)) sdc_if_inst ();
  sdc_device sdc_device_inst (.CLK(clk), .RST_N(rst_n), .CE(ce), .BUS(sdc_if_inst),
    .SAMPLE(sample), .POS_SEL(pos), .NEG_SEL(neg), .CHAN_EN(chan), .TEMP_DIODE_EN(temp),
    .BURNOUT_EN(bo), .BUFFER_EN(bf), .GAIN_CODE(gain), .OFFSET_DAC_REG_SIGN(osg), .OFFSET_DAC_REG_MAG(omag),
    .REF_INT_EN(rint), .REF_HIGH(rhi), .MOD_TICK(tick), .FILTER_SEL(filt),
    .CAL_ACTIVE(cact), .CAL_CODE(ccode));
  sdc_host sdc_host_inst (.CLK(clk), .RST_N(rst_n), .CE(ce), .BUS(sdc_if_inst),
    .CMD_VALID(c_val), .CMD_WRITE(c_wr), .CMD_CAL(c_cal), .CMD_ADDR(c_addr),
    .CMD_WDATA(c_data), .REF_EXT_USED(ref_ext), .CMD_READY(crdy), .RD_DATA(rdd),
    .RD_VALID(rdv), .ZERO_INPUT_REQ(zreq), .FULLSCALE_REQ(freq), .RECAL_NEEDED(recal),
    .RES_DATA(rd24), .RES_VALID(rv), .RES_READY(res_rdy));
  sdc_checker sdc_checker_inst (.CLK(clk), .RST_N(rst_n), .sfr_addr(sdc_if_inst.sfr_addr),
    .sfr_wdata(sdc_if_inst.sfr_wdata), .sfr_we(sdc_if_inst.sfr_we),
    .sfr_re(sdc_if_inst.sfr_re), .sfr_rdata(sdc_if_inst.sfr_rdata),
    .sfr_rvalid(sdc_if_inst.sfr_rvalid), .res_data(sdc_if_inst.res_data),
    .res_valid(sdc_if_inst.res_valid), .res_ready(sdc_if_inst.res_ready));
  always #2.5 clk = ~clk;
  // cycle count, a sample word that never repeats, result tally and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sample <= sample + 24'h00_0001;
    if (rv === 1'b1 && res_rdy === 1'b1) begin
      nres <= nres + 1;
    end
    if (rdv === 1'b1) begin
      nrdv <= nrdv + 1;
    end
    if (cyc == 30000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  // one host command, raised once ready is seen high and held for one edge
  task automatic cmd(input logic w, input logic c, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (crdy !== 1'b1 && n < 100) begin
      step(1);
      n = n + 1;
    end
    c_val = 1'b1;
    c_wr = w;
    c_cal = c;
    c_addr = a;
    c_data = d;
    step(1);
    c_val = 1'b0;
    step(5);
  endtask : cmd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd(1'b1, 1'b0, a, d);
  endtask : wr
  // read data stands until the next read, so it is judged after the command
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    int r0;
    r0 = nrdv;
    cmd(1'b0, 1'b0, a, 8'h00);
    chk(rdd, e);
    chk(nrdv - r0, 1);
  endtask : rdchk
  // spacing of two pulses of the tick (s=0) or of the result valid (s=1)
  task automatic gap(input logic s, output int g);
    int n;
    n = 0;
    while ((s ? rv : tick) !== 1'b1 && n < 5000) begin
      step(1);
      n = n + 1;
    end
    step(1);
    g = 1;
    while ((s ? rv : tick) !== 1'b1 && g < 5000) begin
      step(1);
      g = g + 1;
    end
  endtask : gap
  task automatic t_reset();
    chk(recal, 1'b1);
    chk({rint, rhi, pos, neg, chan}, {2'b11, 3'h0, 3'h1, 1'b1});
    rdchk(`SDC_ADDR_ACTL, `SDC_RST_ACTL);
    rdchk(`SDC_ADDR_MUX, `SDC_RST_MUX);
    rdchk(`SDC_ADDR_ACLK, `SDC_RST_ACLK);
    rdchk(`SDC_ADDR_DECHI, `SDC_RST_DECHI);
    rdchk(8'h00, 8'h00);
  endtask : t_reset
  task automatic t_mux();
    logic [2:0] p, n;
    for (int i = 0; i < 16; i++) begin
      p = i[2:0];
      n = ~i[2:0];
      wr(`SDC_ADDR_MUX, {i[3], p, 1'b0, n});
      chk({pos, neg, chan, temp}, i[3] ? {n, p, 2'b10} : {p, n, 2'b10});
    end
    wr(`SDC_ADDR_MUX, `SDC_MUX_TEMP);
    chk({chan, temp}, 2'b01);
  endtask : t_mux
  task automatic t_actl();
    for (int g = 0; g < 8; g++) begin
      wr(`SDC_ADDR_ACTL, {1'b0, g[0], g[1], 1'b1, g[2], g[2:0]});
      chk({bo, rhi, rint, bf, gain}, {g[0], g[1], 1'b1, g[2], g[2:0]});
      chk(recal, 1'b1);
    end
    ref_ext = 1'b1;
    wr(`SDC_ADDR_ACTL, 8'h38);
    chk(rint, 1'b0);
    ref_ext = 1'b0;
    wr(`SDC_ADDR_ACTL, 8'h30);
    wr(`SDC_ADDR_OFFSET_DAC_REG, 8'h85);
    chk({osg, omag}, {1'b1, 7'h05});
    wr(`SDC_ADDR_OFFSET_DAC_REG, 8'h7f);
    chk({osg, omag}, {1'b0, 7'h7f});
  endtask : t_actl
  task automatic t_rate();
    int g, n;
    wr(`SDC_ADDR_ACLK, 8'h02);
    step(400);
    gap(1'b0, g);
    chk(g, 192);
    // enable low freezes the divider chain where it stands
    step(4);
    ce = 1'b0;
    step(300);
    ce = 1'b1;
    n = 0;
    while (tick !== 1'b1 && n < 1000) begin
      step(1);
      n = n + 1;
    end
    chk(n, 192 - 4);
    wr(`SDC_ADDR_ACLK, 8'h00);
    wr(`SDC_ADDR_DECLO, 8'h02);
    wr(`SDC_ADDR_CCTL, 8'h10);
    step(300);
    gap(1'b1, g);
    chk(g, 128);
    wr(`SDC_ADDR_DECLO, 8'h01);
    rdchk(`SDC_ADDR_DECLO, 8'h01);
  endtask : t_rate
  task automatic t_filt();
    int n, s2, r0;
    for (int f = 1; f < 4; f++) begin
      wr(`SDC_ADDR_CCTL, {2'b00, f[1:0], 4'h0});
      chk(filt, f[1:0]);
    end
    wr(`SDC_ADDR_CCTL, 8'h00);
    wr(`SDC_ADDR_MUX, 8'h12);
    chk(filt, 2'h1);
    r0 = nres;
    n = 0;
    s2 = 0;
    while (filt !== 2'h3 && n < 1000) begin
      s2 = s2 + ((filt === 2'h2) ? 1 : 0);
      step(1);
      n = n + 1;
    end
    step(8);
    chk(s2, 64);
    chk(nres - r0, 2);
  endtask : t_filt
  // every calibration kind; a stale offset code is loaded first on purpose
  task automatic t_cal();
    logic [2:0] c;
    int np, d, r0;
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 3'h1 : 3'(k + 3);
      np = (k == 0) ? 14 : 7;
      wr(`SDC_ADDR_OFFSET_DAC_REG, 8'h44);
      cmd(1'b0, 1'b1, 8'h00, {5'h00, c});
      chk({ccode, cact, recal}, {c, 2'b10});
      chk({zreq, freq}, {c == 3'h4, c == 3'h5});
      // cleared flag stays low while busy; the two commands take 12 cycles
      wr(`SDC_ADDR_STAT, 8'h01);
      rdchk(`SDC_ADDR_STAT, 8'h02);
      r0 = nres;
      d = 12;
      while (cact === 1'b1 && d < 2000) begin
        step(1);
        d = d + 1;
      end
      chk(nres - r0, 0);
      chk(d + 8 > (np - 1) * 64 && d <= np * 64, 1'b1);
      rdchk(`SDC_ADDR_STAT, 8'h01);
      rdchk(`SDC_ADDR_CCTL, 8'h00);
      rdchk(`SDC_ADDR_OFFSET_DAC_REG, 8'h00);
    end
  endtask : t_cal
  // stall the far side until the buffer refuses, then drain it
  task automatic t_fifo();
    int r0, k;
    logic [23:0] prev;
    res_rdy = 1'b0;
    step(640);
    r0 = nres;
    res_rdy = 1'b1;
    k = 0;
    prev = rd24;
    // held word and four buffered ones come one conversion apart
    repeat (30) begin
      if (rv === 1'b1) begin
        if (k > 0 && k < 5) chk(rd24 - prev, 24'h00_0040);
        prev = rd24;
        k = k + 1;
      end
      step(1);
    end
    chk((nres - r0) inside {5, 6}, 1'b1);
  endtask : t_fifo
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(2);
    t_reset();
    wr(`SDC_ADDR_DECHI, 8'h00);
    wr(`SDC_ADDR_DECLO, 8'h01);
    t_mux();
    t_actl();
    t_rate();
    t_filt();
    t_cal();
    t_fifo();
    close_out();
  end
endmodule : sigma_delta_adc_control_tb
`default_nettype wire
